//--- hdl/axil_reg_slave.sv
// axi4-lite slave front end for the sequencer registers
`timescale 1ns/10ps
module axil_reg_slave (
   input  logic        aclk,
   input  logic        aresetn,
   input  logic [3:0]  awaddr,
   input  logic        awvalid,
   output logic        awready,
   input  logic [31:0] wdata,
   input  logic [3:0]  wstrb,
   input  logic        wvalid,
   output logic        wready,
   output logic [1:0]  bresp,
   output logic        bvalid,
   input  logic        bready,
   input  logic [3:0]  araddr,
   input  logic        arvalid,
   output logic        arready,
   output logic [31:0] rdata,
   output logic [1:0]  rresp,
   output logic        rvalid,
   input  logic        rready,
   output logic        wr_en,
   output logic [3:0]  wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0]  wr_strb,
   input  logic        wr_ok,
   output logic [3:0]  rd_addr,
   input  logic [31:0] rd_data,
   input  logic        rd_ok
);
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [3:0]  awaddr_q, awaddr_d, wstrb_q, wstrb_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

   assign awready = awready_q;
   assign wready  = wready_q;
   assign arready = arready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign wr_addr = awaddr_q;
   assign wr_data = wdata_q;
   assign wr_strb = wstrb_q;
   assign rd_addr = araddr;

   always_comb begin
      aw_held_d = aw_held_q;
      awaddr_d  = awaddr_q;
      w_held_d  = w_held_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      wr_en     = 1'b0;
      if (awvalid && awready_q) begin
         aw_held_d = 1'b1;
         awaddr_d  = awaddr;
      end
      if (wvalid && wready_q) begin
         w_held_d = 1'b1;
         wdata_d  = wdata;
         wstrb_d  = wstrb;
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      // both halves present: commit and answer
      if (aw_held_q && w_held_q && !bvalid_q) begin
         wr_en     = wr_ok;
         bvalid_d  = 1'b1;
         bresp_d   = wr_ok ? resp_okay : resp_slverr;
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
      end
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d  = rd_ok ? rd_data : 32'h0000_0000;
         rresp_d  = rd_ok ? resp_okay : resp_slverr;
      end
      awready_d = !aw_held_d && !bvalid_d;
      wready_d  = !w_held_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 4'h0;
         w_held_q  <= 1'b0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= 2'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         aw_held_q <= aw_held_d;
         awaddr_q  <= awaddr_d;
         w_held_q  <= w_held_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         arready_q <= arready_d;
      end
   end
endmodule

//--- hdl/sar_conversion_sequencer.sv
// constants package and top of the successive-approximation sequencer
// What this block does
// - falling conversion-start edge ends acquisition, holds the input, starts conversion.
// - sixteen binary-weighted trials decide bits msb first from the comparator.
// - after the search the output word is formed, then busy drops.
// - each result belongs to the conversion just finished, no latency.
// - fastest mode reaches 1 msps; accuracy needs starts within 1 ms.
// - normal mode reaches 800 ksps with no limit on spacing.
// - low-power mode powers the converter down between conversions.
// - coding select picks straight binary or two's complement (msb inverted).
// - one step is reference over 65536; codes per the transfer table.
// - input above reference saturates to ffff or 7fff.
// - input below ground sense saturates to 0000 or 8000.
// - reset bit high resets the logic and aborts any conversion.
// - sleep request lets the conversion finish then refuses new starts.
// - low-power mode auto-starts if start is still low when acquisition ends.
`timescale 1ns/10ps
package sar_seq_pkg;
   localparam int          clk_mhz         = 200;
   localparam int          res_w           = 16;
   localparam int          trial_fast_ns   = 45;
   localparam int          trial_norm_ns   = 60;
   localparam int          acq_ns          = 250;
   localparam int          gap_limit_ns    = 1000000;
   localparam int          trial_fast_cyc  = (trial_fast_ns * clk_mhz + 999) / 1000;
   localparam int          trial_norm_cyc  = (trial_norm_ns * clk_mhz + 999) / 1000;
   localparam int          acq_cyc         = (acq_ns * clk_mhz + 999) / 1000;
   localparam int          gap_limit_cyc   = (gap_limit_ns * clk_mhz) / 1000;
   localparam int          gap_w           = 20;
   localparam int          addr_w          = 4;
   localparam logic [3:0]  ctrl_off        = 4'h0;
   localparam logic [3:0]  status_off      = 4'h4;
   localparam logic [3:0]  result_off      = 4'h8;
   localparam int          ctrl_abort_bit  = 0;
   localparam int          ctrl_sleep_bit  = 1;
   localparam int          ctrl_coding_bit = 2;
   localparam int          ctrl_lp_bit     = 3;
   localparam int          ctrl_fast_bit   = 4;
   localparam logic [4:0]  ctrl_reset_val  = 5'h00;
   localparam logic [15:0] msb_trial       = 16'h8000;
   localparam logic [15:0] code_full       = 16'hffff;
   localparam logic [15:0] code_zero       = 16'h0000;
   localparam logic [3:0]  top_idx         = 4'hf;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_conv = 2'b01,
      st_form = 2'b10,
      st_acq  = 2'b11
   } seq_state_t;

   function automatic logic addr_hit(input logic [3:0] a);
      return (a == ctrl_off) || (a == status_off) || (a == result_off);
   endfunction

   function automatic logic [15:0] code_word(input logic [15:0] sar, input logic over,
                                              input logic under, input logic twos);
      logic [15:0] raw;
      raw = over ? code_full : (under ? code_zero : sar);
      return raw ^ {twos, 15'h0000};
   endfunction

   function automatic logic [15:0] below_mask(input logic [3:0] idx);
      return (16'h0001 << idx) - 16'h0001;
   endfunction
endpackage

module sar_conversion_sequencer #(
   parameter int unsigned gap_limit_cycles = sar_seq_pkg::gap_limit_cyc
) (
   input  logic                         aclk,
   input  logic                         aresetn,
   input  logic [sar_seq_pkg::addr_w-1:0] awaddr,
   input  logic                         awvalid,
   output logic                         awready,
   input  logic [31:0]                  wdata,
   input  logic [3:0]                   wstrb,
   input  logic                         wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  logic                         bready,
   input  logic [sar_seq_pkg::addr_w-1:0] araddr,
   input  logic                         arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  logic                         rready,
   input  logic                         conversion_start_n,
   input  logic                         comparator_keep,
   input  logic                         above_reference,
   input  logic                         below_analog_ground_sense,
   output logic                         busy,
   output logic                         sample_hold,
   output logic [sar_seq_pkg::res_w-1:0] dac_trial,
   output logic                         analog_power
);
   import sar_seq_pkg::*;

   localparam int             fast_busy_cyc = 16 * trial_fast_cyc + 1;
   localparam int             norm_busy_cyc = 16 * trial_norm_cyc + 1;
   localparam logic [gap_w-1:0] gap_lim    = gap_w'(gap_limit_cycles);
   localparam logic [7:0]     acq_last      = 8'(acq_cyc - 1);

   seq_state_t       state_q, state_d;
   logic [4:0]       ctrl_q, ctrl_d;
   logic [15:0]      sar_q, sar_d, result_q, result_d;
   logic [3:0]       idx_q, idx_d;
   logic [7:0]       cnt_q, cnt_d;
   logic [gap_w-1:0] gap_q, gap_d;
   logic             busy_q, busy_d, hold_q, hold_d, power_q, power_d;
   logic             over_q, over_d, under_q, under_d, fast_q, fast_d, coding_q, coding_d;
   logic             stale_q, stale_d, first_q, first_d, start_prev_q;
   logic             wr_en, wr_ok, rd_ok, start_edge, start_ok, lp_mode, abort;
   logic [3:0]       wr_addr, wr_strb, rd_addr;
   logic [31:0]      wr_data, rd_data;
   logic [7:0]       trial_last;

   axil_reg_slave u_bus (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wr_en, .wr_addr,
      .wr_data, .wr_strb, .wr_ok, .rd_addr, .rd_data, .rd_ok
   );

   assign busy         = busy_q;
   assign sample_hold  = hold_q;
   assign dac_trial    = sar_q;
   assign analog_power = power_q;
   assign wr_ok        = addr_hit(wr_addr);
   assign rd_ok        = addr_hit(rd_addr);
   assign start_edge   = start_prev_q && !conversion_start_n;
   assign abort        = ctrl_q[ctrl_abort_bit];
   assign start_ok     = !ctrl_q[ctrl_sleep_bit] && !abort;
   assign lp_mode      = ctrl_q[ctrl_lp_bit] && !ctrl_q[ctrl_fast_bit];
   assign trial_last   = fast_q ? 8'(trial_fast_cyc - 1) : 8'(trial_norm_cyc - 1);

   // register read data
   always_comb begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         ctrl_off:   rd_data = {27'h0000000, ctrl_q};
         status_off: rd_data = {28'h0000000, ctrl_q[ctrl_sleep_bit] && (state_q == st_idle),
                                power_q, stale_q, busy_q};
         result_off: rd_data = {16'h0000, result_q};
         default:    rd_data = 32'h0000_0000;
      endcase
   end

   // sequencer next state
   always_comb begin
      state_d  = state_q;
      ctrl_d   = ctrl_q;
      sar_d    = sar_q;
      result_d = result_q;
      idx_d    = idx_q;
      cnt_d    = cnt_q;
      busy_d   = busy_q;
      hold_d   = hold_q;
      over_d   = over_q;
      under_d  = under_q;
      fast_d   = fast_q;
      coding_d = coding_q;
      stale_d  = stale_q;
      first_d  = first_q;
      gap_d    = (gap_q >= gap_lim) ? gap_q : gap_q + {{(gap_w-1){1'b0}}, 1'b1};
      if (wr_en && (wr_addr == ctrl_off) && wr_strb[0]) begin
         ctrl_d = wr_data[4:0];
      end
      case (state_q)
         st_idle: begin
            if (start_edge && start_ok) begin
               state_d = st_conv;
            end
         end
         st_conv: begin
            if (cnt_q == trial_last) begin
               cnt_d        = 8'h00;
               sar_d[idx_q] = comparator_keep;
               if (idx_q == 4'h0) begin
                  state_d = st_form;
               end else begin
                  sar_d[idx_q - 4'h1] = 1'b1;
                  idx_d               = idx_q - 4'h1;
               end
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
         end
         st_form: begin
            result_d = code_word(sar_q, over_q, under_q, coding_q);
            busy_d   = 1'b0;
            hold_d   = 1'b0;
            cnt_d    = 8'h00;
            state_d  = st_acq;
         end
         st_acq: begin
            cnt_d = cnt_q + 8'h01;
            if (start_edge && start_ok && !lp_mode) begin
               state_d = st_conv;
            end else if (cnt_q == acq_last) begin
               state_d = (lp_mode && !conversion_start_n && start_ok) ? st_conv : st_idle;
            end
         end
         default: state_d = st_idle;
      endcase
      // entering conversion: hold input, msb trial, busy high
      if ((state_d == st_conv) && (state_q != st_conv)) begin
         busy_d   = 1'b1;
         hold_d   = 1'b1;
         sar_d    = msb_trial;
         idx_d    = top_idx;
         cnt_d    = 8'h00;
         over_d   = above_reference;
         under_d  = below_analog_ground_sense;
         fast_d   = ctrl_q[ctrl_fast_bit];
         coding_d = ctrl_q[ctrl_coding_bit];
         stale_d  = ctrl_q[ctrl_fast_bit] && (first_q || (gap_q >= gap_lim));
         first_d  = 1'b0;
         gap_d    = {gap_w{1'b0}};
      end
      if (abort) begin
         state_d = st_idle;
         busy_d  = 1'b0;
         hold_d  = 1'b0;
         sar_d   = code_zero;
         idx_d   = 4'h0;
         cnt_d   = 8'h00;
         first_d = 1'b1;
      end
      power_d = (state_d != st_idle) || (!ctrl_q[ctrl_lp_bit] && !ctrl_q[ctrl_sleep_bit]) ||
                (ctrl_q[ctrl_fast_bit] && !ctrl_q[ctrl_sleep_bit]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q      <= st_idle;
         ctrl_q       <= ctrl_reset_val;
         sar_q        <= 16'h0000;
         result_q     <= 16'h0000;
         idx_q        <= 4'h0;
         cnt_q        <= 8'h00;
         gap_q        <= {gap_w{1'b0}};
         busy_q       <= 1'b0;
         hold_q       <= 1'b0;
         power_q      <= 1'b0;
         over_q       <= 1'b0;
         under_q      <= 1'b0;
         fast_q       <= 1'b0;
         coding_q     <= 1'b0;
         stale_q      <= 1'b0;
         first_q      <= 1'b1;
         start_prev_q <= 1'b1;
      end else begin
         state_q      <= state_d;
         ctrl_q       <= ctrl_d;
         sar_q        <= sar_d;
         result_q     <= result_d;
         idx_q        <= idx_d;
         cnt_q        <= cnt_d;
         gap_q        <= gap_d;
         busy_q       <= busy_d;
         hold_q       <= hold_d;
         power_q      <= power_d;
         over_q       <= over_d;
         under_q      <= under_d;
         fast_q       <= fast_d;
         coding_q     <= coding_d;
         stale_q      <= stale_d;
         first_q      <= first_d;
         start_prev_q <= conversion_start_n;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_start_holds;
      (state_q == st_idle) && start_edge && start_ok |=> busy_q && sample_hold && (dac_trial == msb_trial);
   endproperty
   a_start_holds: assert property (p_start_holds) else $error("start edge did not begin conversion");
   property p_msb_first;
      (state_q == st_conv) |-> dac_trial[idx_q] && ((dac_trial & below_mask(idx_q)) == 16'h0000);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("trial bits not msb first");
   property p_busy_after_form;
      $fell(busy_q) && !$past(abort) |-> $past(state_q) == st_form;
   endproperty
   a_busy_after_form: assert property (p_busy_after_form) else $error("busy fell before code formed");
   property p_result_current;
      $fell(busy_q) && !$past(abort) && !over_q && !under_q |-> (result_q ^ {coding_q, 15'h0000}) == $past(sar_q);
   endproperty
   a_result_current: assert property (p_result_current) else $error("result not from this conversion");
   property p_fast_time;
      disable iff (!aresetn || abort)
      $rose(busy_q) && fast_d == fast_q && ctrl_q[ctrl_fast_bit] && !abort |-> ##fast_busy_cyc !busy_q;
   endproperty
   a_fast_time: assert property (p_fast_time) else $error("fast conversion length wrong");
   property p_norm_time;
      disable iff (!aresetn || abort) $rose(busy_q) && !ctrl_q[ctrl_fast_bit] && !abort |-> ##norm_busy_cyc !busy_q;
   endproperty
   a_norm_time: assert property (p_norm_time) else $error("normal conversion length wrong");
   property p_lp_off;
      (state_q == st_idle) && $past(ctrl_q[ctrl_lp_bit]) && !$past(ctrl_q[ctrl_fast_bit]) |-> !analog_power;
   endproperty
   a_lp_off: assert property (p_lp_off) else $error("power on while idle in low-power mode");
   property p_over_clamp;
      $fell(busy_q) && !$past(abort) && over_q |-> result_q == (coding_q ? 16'h7fff : 16'hffff);
   endproperty
   a_over_clamp: assert property (p_over_clamp) else $error("overrange not saturated");
   property p_under_clamp;
      $fell(busy_q) && !$past(abort) && !over_q && under_q |-> result_q == (coding_q ? 16'h8000 : 16'h0000);
   endproperty
   a_under_clamp: assert property (p_under_clamp) else $error("underrange not saturated");
   property p_abort;
      abort |=> !busy_q && !sample_hold && (state_q == st_idle);
   endproperty
   a_abort: assert property (p_abort) else $error("reset did not abort");
   property p_sleep_refuse;
      (state_q == st_idle) && ctrl_q[ctrl_sleep_bit] |=> !busy_q;
   endproperty
   a_sleep_refuse: assert property (p_sleep_refuse) else $error("conversion started while asleep");
   property p_lp_autostart;
      (state_q == st_acq) && (cnt_q == acq_last) && lp_mode && !conversion_start_n && start_ok |=> busy_q;
   endproperty
   a_lp_autostart: assert property (p_lp_autostart) else $error("no auto start after acquisition");
   property p_ignore_busy;
      (state_q == st_conv) && (idx_q != top_idx) && start_edge && !abort |=> idx_q != top_idx;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) else $error("start edge restarted busy conversion");
   c_fast_conv:  cover property ($rose(busy_q) && ctrl_q[ctrl_fast_bit]);
   c_lp_auto:    cover property ((state_q == st_acq) && lp_mode && (state_d == st_conv));
   c_over_range: cover property ($fell(busy_q) && over_q);
   c_abort_conv: cover property ((state_q == st_conv) && abort);
endmodule

//--- dv/analog_front_model.sv
// comparator model standing in for the sampled analog input
`timescale 1ns/10ps
module analog_front_model (
   input  logic [15:0] dac_trial,
   input  logic [15:0] level,
   output logic        comparator_keep
);
   // keep the trial bit while the trial word does not exceed the held level
   assign comparator_keep = (dac_trial <= level);
endmodule

//--- dv/tb_top.sv
// self-checking bench for the sar conversion sequencer
`timescale 1ns/10ps
module tb_top;
   import sar_seq_pkg::*;
   localparam int tn = 16 * trial_norm_cyc + 1;
   localparam int tf = 16 * trial_fast_cyc + 1;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, comparator_keep, busy, sample_hold;
   logic        conversion_start_n, above_reference, below_analog_ground_sense, analog_power;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] dac_trial, level;
   logic [33:0] exp_q[$];
   int          n_errors, compares, seed, w, c, k;

   sar_conversion_sequencer #(.gap_limit_cycles(300)) dut_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .conversion_start_n, .comparator_keep, .above_reference,
      .below_analog_ground_sense, .busy, .sample_hold, .dac_trial, .analog_power
   );
   analog_front_model cmp_u (.dac_trial, .level, .comparator_keep);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic give_verdict();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 3000) begin
         $display("CHECK FAILED at %0t: wait ran out", $time);
         n_errors++;
         give_verdict();
      end
   endtask

   // expected output word from level, range flags and coding
   function automatic logic [15:0] code(input logic [15:0] v, input logic ov, un, tw);
      code = (ov ? 16'hffff : (un ? 16'h0000 : v)) ^ {tw, 15'h0000};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      tick(n);
      exp_q.push_back({e, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         tick(n);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (bvalid !== 1'b1) tick(n);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      int n;
      n = 0;
      tick(n);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do tick(n); while (!arready);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) tick(n);
      rready <= 1'b0;
   endtask

   // one conversion; g pulses a second start edge while busy
   task automatic conv(input logic [15:0] v, input logic ov, un, tw, g, input int tt);
      int n;
      n = 0;
      tick(n);
      level <= v;
      above_reference <= ov;
      below_analog_ground_sense <= un;
      conversion_start_n <= 1'b0;
      while (busy !== 1'b1) tick(n);
      w = n;
      n = 0;
      conversion_start_n <= 1'b1;
      while (busy === 1'b1) begin
         tick(n);
         if (g && (n == 20 || n == 22)) conversion_start_n <= (n == 22);
      end
      chk(34'(n), 34'(tt));
      rd(result_off, {18'h0, code(v, ov, un, tw)});
   endtask

   // result checker: oldest note against each response
   always @(posedge aclk) begin
      if ((rvalid && rready) || (bvalid && bready)) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("CHECK FAILED at %0t: response with no expected note", $time);
         end else begin
            chk(rvalid ? {rresp, rdata} : {bresp, 32'h0}, exp_q.pop_front());
         end
      end
   end

   initial begin
      seed = 96;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, above_reference, below_analog_ground_sense} = '0;
      {awaddr, araddr, wdata, level} = '0;
      wstrb = 4'hf;
      conversion_start_n = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // sleep refuses starts
      wr(ctrl_off, 32'h2, 2'b00);
      conversion_start_n <= 1'b0;
      repeat (30) @(posedge aclk);
      chk(34'({busy, analog_power}), 34'h0);
      rd(status_off, 34'h8);
      conversion_start_n <= 1'b1;
      // register map corners
      wr(ctrl_off, 32'h4, 2'b00);
      wstrb <= 4'he;
      wr(ctrl_off, 32'h10, 2'b00);
      wstrb <= 4'hf;
      wr(status_off, 32'h1f, 2'b00);
      wr(4'hc, 32'h1, 2'b10);
      rd(ctrl_off, 34'h4);
      rd(4'hc, {2'b10, 32'h0});
      // both codings, in range and saturated, back to back
      for (c = 0; c < 2; c++) begin
         wr(ctrl_off, 32'(c << 2), 2'b00);
         for (k = 0; k < 3; k++) begin
            conv(16'($random(seed)), k == 1, k == 2, c[0], c == 0 && k == 0, tn);
         end
      end
      // abort mid conversion
      conversion_start_n <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(34'({busy, sample_hold, dac_trial}), 34'h38000);
      conversion_start_n <= 1'b1;
      wr(ctrl_off, 32'h1, 2'b00);
      repeat (2) @(posedge aclk);
      chk(34'({busy, sample_hold}), 34'h0);
      // fast mode: stale marking after abort and after a long gap
      wr(ctrl_off, 32'h10, 2'b00);
      for (k = 0; k < 3; k++) begin
         if (k == 2) repeat (400) @(posedge aclk);
         conv(16'($random(seed)), 1'b0, 1'b0, 1'b0, 1'b0, tf);
         rd(status_off, k == 1 ? 34'h4 : 34'h6);
      end
      // low power: idle power off, held start waits out acquisition
      wr(ctrl_off, 32'h8, 2'b00);
      repeat (80) @(posedge aclk);
      chk(34'(analog_power), 34'h0);
      conv(16'($random(seed)), 1'b0, 1'b0, 1'b0, 1'b0, tn);
      conv(16'($random(seed)), 1'b0, 1'b0, 1'b0, 1'b0, tn);
      chk(34'(w > 30), 34'h1);
      give_verdict();
   end
endmodule
